// ### sgf_cfg.svh
// constants of the setup-frame address filter
`ifndef SGF_CFG_SVH
`define SGF_CFG_SVH
`define SGF_OWN_BIT      31
`define SGF_ERRSUM_BIT   15
`define SGF_SETERR_BIT   13
`define SGF_IC_BIT       24
`define SGF_HASH_BIT     25
`define SGF_INV_BIT      26
`define SGF_DT_HI        29
`define SGF_DT_LO        28
`define SGF_DT_SETUP     2'h2
`define SGF_BS_HI        30
`define SGF_BS_LO        16
`define SGF_BS_SETUP     15'h0080
`define SGF_PA_HI        29
`define SGF_PA_LO        1
`define SGF_BUF_WORDS    6'h20
`define SGF_PHYS_LO_IDX  5'h10
`define SGF_PHYS_HI_IDX  5'h11
`define SGF_CRC_INIT     32'hFFFF_FFFF
`define SGF_CRC_POLY     32'h04C1_1DB7
`define SGF_OFF_CTRL     4'h0
`define SGF_OFF_STAT     4'h4
`define SGF_CTRL_TXRUN   0
`define SGF_CTRL_PROMISC 1
`define SGF_CTRL_ALLMC   2
`define SGF_STAT_TI      0
`define SGF_STAT_BUSY    1
`define SGF_STAT_HASH    2
`define SGF_STAT_INV     3
`define SGF_STAT_SERR    4
`endif

// ### sgf_filter_checker.sv
// port assertions of the setup-frame address filter
`timescale 1ns/1ps
module sgf_filter_checker
  import sgf_pkg::*;
(
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  // descriptor side
  input wire sgf_desc_t   descIn,
  input wire logic        descTaken,
  input wire logic        descWbValid,
  input wire logic [31:0] descWbWord0,
  input wire logic        txQueueEmpty,
  // buffer, receive and status
  input wire logic        bufReady,
  input wire logic        rxBusy,
  input wire logic        rxAddrValid,
  input wire logic        rxDisconnect,
  input wire logic        filterValid,
  input wire logic        filterAccept,
  input wire logic        transmit_interrupt_flag
);
`include "sgf_cfg.svh"
  logic icHeld_q; // completion request of the setup in flight
  logic icHeld_d;
  // capture the request while the taken descriptor still stands
  always_comb begin
    icHeld_d = descTaken ? descIn.setup_desc_word1[`SGF_IC_BIT] : icHeld_q;
  end
  always_ff @(posedge sys_clk) begin
    icHeld_q <= sys_rst ? 1'b0 : icHeld_d;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  AST_VERDICT_LAT: assert property (
    rxAddrValid && !rxDisconnect |=> filterValid) else $error("no verdict");
  AST_VERDICT_CAUSE: assert property (
    filterValid |-> $past(rxAddrValid) && !$past(rxDisconnect))
    else $error("verdict without cause");
  AST_ACCEPT_QUAL: assert property (
    filterAccept |-> filterValid) else $error("accept without verdict");
  AST_DISC_LOAD: assert property (
    bufReady |-> rxDisconnect) else $error("connected while loading");
  AST_TAKEN_PULSE: assert property (
    descTaken |=> !descTaken) else $error("taken longer than a cycle");
  AST_WAIT_COND: assert property (
    $rose(bufReady) |-> $past(txQueueEmpty) && !$past(rxBusy))
    else $error("load started too early");
  AST_WB_WORD: assert property (
    descWbValid |-> !descWbWord0[`SGF_OWN_BIT] &&
    descWbWord0[`SGF_ERRSUM_BIT] == descWbWord0[`SGF_SETERR_BIT])
    else $error("bad write-back word");
  AST_WB_AFTER: assert property (
    $fell(bufReady) |=> descWbValid) else $error("late write-back");
  AST_TI_SET: assert property (
    descWbValid && icHeld_q |-> transmit_interrupt_flag)
    else $error("flag not raised");
  AST_TI_CAUSE: assert property (
    $rose(transmit_interrupt_flag) |-> descWbValid)
    else $error("flag without completion");
  cover property (descWbValid && descWbWord0[`SGF_SETERR_BIT]);
  cover property (filterValid && filterAccept);
  cover property ($rose(rxDisconnect));
endmodule // sgf_filter_checker

bind sgf_filter_top sgf_filter_checker sgf_filter_checker_i (
  .sys_clk, .sys_rst, .descIn, .descTaken, .descWbValid, .descWbWord0,
  .txQueueEmpty, .bufReady, .rxBusy, .rxAddrValid, .rxDisconnect,
  .filterValid, .filterAccept, .transmit_interrupt_flag);

// ### sgf_filter_top.sv
// setup-frame loader, filter table and destination filter
//
// Functional notes
// RL1 - perfect mode: sixteen 48-bit addresses compared
// RL2 - imperfect mode: 512-bit hash plus one address
// RL3 - host queues setup before reception starts
// RL4 - cleared table accepts only all-zero destination
// RL5 - setup waits for tx running, idle queue, rx
// RL6 - receiver disconnected while setup is loaded
// RL7 - wrong size sets setup and summary errors
// RL8 - ownership bit cleared when setup completes
// RL9 - completion flag raises transmit interrupt flag
// RL10 - descriptor bit picks hash or exact table
// RL11 - inverse filtering only exact, no promisc/allmulti
// RL12 - host sets type two and size 128
// RL13 - host gives word-aligned buffer pointer
// RL14 - host always supplies all sixteen addresses
// RL15 - lowest bit of first byte marks multicast
// RL16 - multicast: crc top nine bits index table
// RL17 - imperfect physical frames need stored address
// RL18 - index n: bit n%32 of word n/32
// RL19 - crc starts ones, 48 bits lsb first
// RL20 - setup frame never transmitted nor looped back
// RL21 - imperfect physical address follows hash words
`timescale 1ns/1ps
module sgf_filter_top
  import sgf_pkg::*;
#(
  parameter int ENTRIES = 16
)(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // setup descriptor from the transmit list
  input  wire logic        descValid,
  input  wire sgf_desc_t   descIn,
  input  wire logic        txQueueEmpty,
  output logic             descTaken,
  output logic             descWbValid,
  output logic      [31:0] descWbWord0,
  // setup buffer words
  output logic      [28:0] bufPhysPointer,
  input  wire logic        bufValid,
  input  wire logic [31:0] bufData,
  output logic             bufReady,
  // receive side
  input  wire logic        rxBusy,
  input  wire logic        rxAddrValid,
  input  wire logic [47:0] rxAddr,
  output logic             rxDisconnect,
  output logic             filterValid,
  output logic             filterAccept,
  // transmit interrupt status
  output logic             transmit_interrupt_flag
);
`include "sgf_cfg.svh"

  // register bus state
  logic        wrPend_q, wrPend_d;    // write data phase pending
  logic [3:0]  wrOff_q, wrOff_d;      // latched write offset
  logic [31:0] rdata_q, rdata_d;      // read data for data phase
  logic [2:0]  ctrl_q, ctrl_d;        // txrun, promisc, allmulti
  logic        ti_q, ti_d;            // sticky transmit interrupt
  logic        serr_q, serr_d;        // last setup had size error
  // sequencer state
  sgf_state_t  state_q, state_d;      // setup sequencer
  sgf_desc_t   desc_q, desc_d;        // held descriptor
  logic [5:0]  wcnt_q, wcnt_d;        // buffer words taken
  logic        hashMode_q, hashMode_d; // imperfect mode
  logic        inverse_q, inverse_d;  // inverse filtering
  // output flops
  logic        taken_q, taken_d;
  logic        wbValid_q, wbValid_d;
  logic [31:0] wbWord_q, wbWord_d;
  logic        fValid_q, fValid_d;
  logic        fAccept_q, fAccept_d;
  // table, 32 longwords as laid out in the setup buffer
  logic [31:0] tbl_q [0:31];
  logic [31:0] tbl_d [0:31];

  // derived
  logic [ENTRIES*48-1:0] entries;     // exact entries, packed
  logic        exactHit;              // destination in exact table
  logic [8:0]  hashIdx;               // hash table index
  logic        hashBit;               // selected hash bit
  logic [47:0] physAddr;              // imperfect station address
  logic        isMcast;               // destination is multicast
  logic        wrStart;               // write address phase
  logic        rdStart;               // read address phase
  logic        descOk;                // descriptor fit for setup
  logic        sizeOk;                // buffer size is 128
  logic        accept;                // combinational verdict
  logic        tiSet;                 // completion event

  // address i is word 2i (low four bytes) and low half of 2i+1 [RL1]
  for (genvar i = 0; i < ENTRIES; i++) begin : g_ent
    assign entries[i*48 +: 48] = {tbl_q[2*i+1][15:0], tbl_q[2*i]};
  end

  sgf_match #(
    .ENTRIES (ENTRIES)
  ) u_match (
    .dstAddr (rxAddr),
    .entries (entries),
    .hit     (exactHit)
  );

  sgf_hash_crc u_crc (
    .dstAddr (rxAddr),
    .hashIdx (hashIdx)
  );

  // index n picks bit n mod 32 of longword n / 32 [RL18]
  assign hashBit  = tbl_q[hashIdx[8:5]][hashIdx[4:0]];
  // station address sits after the sixteen hash words [RL21]
  assign physAddr = {tbl_q[`SGF_PHYS_HI_IDX][15:0],
                     tbl_q[`SGF_PHYS_LO_IDX]};
  assign isMcast  = rxAddr[0]; // [RL15]

  assign wrStart = hsel & hready & htrans[1] & hwrite;
  assign rdStart = hsel & hready & htrans[1] & ~hwrite;
  assign descOk  = descIn.setup_desc_word0[`SGF_OWN_BIT] &
                   (descIn.setup_desc_word1[`SGF_DT_HI:`SGF_DT_LO] ==
                    `SGF_DT_SETUP);
  assign sizeOk  = (desc_q.setup_desc_word2[`SGF_BS_HI:`SGF_BS_LO] ==
                    `SGF_BS_SETUP);

  // destination verdict from mode and control bits
  always_comb begin
    accept = 1'b0;
    if (ctrl_q[`SGF_CTRL_PROMISC]) begin
      accept = 1'b1;
    end else if (hashMode_q) begin
      // multicast by hash, physical by the single address
      if (isMcast) begin
        accept = ctrl_q[`SGF_CTRL_ALLMC] | hashBit; // [RL16] [RL2]
      end else begin
        accept = (rxAddr == physAddr); // [RL17]
      end
    end else if (isMcast && ctrl_q[`SGF_CTRL_ALLMC]) begin
      accept = 1'b1;
    end else if (inverse_q && !ctrl_q[`SGF_CTRL_ALLMC]) begin
      accept = ~exactHit; // [RL11]
    end else begin
      // zero table after reset matches only the all-zero address
      accept = exactHit; // [RL1] [RL4]
    end
  end

  // sequencer, descriptor and table next values
  always_comb begin
    state_d    = state_q;
    desc_d     = desc_q;
    wcnt_d     = wcnt_q;
    hashMode_d = hashMode_q;
    inverse_d  = inverse_q;
    serr_d     = serr_q;
    taken_d    = 1'b0;
    wbValid_d  = 1'b0;
    wbWord_d   = wbWord_q;
    tiSet      = 1'b0;
    for (int k = 0; k < 32; k++) begin
      tbl_d[k] = tbl_q[k];
    end
    case (state_q)
      SGF_IDLE: begin
        // accepted in any receive state [RL5]
        if (descValid && descOk) begin
          desc_d  = descIn;
          taken_d = 1'b1;
          state_d = SGF_WAIT;
        end
      end
      SGF_WAIT: begin
        // tx running, queue drained, no frame mid-reception [RL5]
        if (ctrl_q[`SGF_CTRL_TXRUN] && txQueueEmpty && !rxBusy) begin
          wcnt_d = 6'h00;
          if (sizeOk) begin
            hashMode_d = desc_q.setup_desc_word1[`SGF_HASH_BIT]; // [RL10]
            inverse_d  = desc_q.setup_desc_word1[`SGF_INV_BIT]; // [RL11]
            state_d    = SGF_LOAD;
          end else begin
            state_d = SGF_DONE;
          end
        end
      end
      SGF_LOAD: begin
        // buffer goes only into the table, never to the wire [RL20]
        if (bufValid) begin
          tbl_d[wcnt_q[4:0]] = bufData; // [RL2] [RL1]
          wcnt_d = wcnt_q + 6'h01;
          if (wcnt_q == `SGF_BUF_WORDS - 6'h01) begin
            state_d = SGF_DONE;
          end
        end
      end
      SGF_DONE: begin
        // hand the descriptor back, flag errors [RL8] [RL7]
        wbWord_d = desc_q.setup_desc_word0;
        wbWord_d[`SGF_OWN_BIT] = 1'b0; // [RL8]
        wbWord_d[`SGF_SETERR_BIT] = ~sizeOk; // [RL7]
        wbWord_d[`SGF_ERRSUM_BIT] = ~sizeOk; // [RL7]
        serr_d    = ~sizeOk;
        wbValid_d = 1'b1;
        tiSet     = desc_q.setup_desc_word1[`SGF_IC_BIT]; // [RL9]
        state_d   = SGF_IDLE;
      end
      default: begin
        state_d = SGF_IDLE;
      end
    endcase
  end

  // bus and receive-verdict next values
  always_comb begin
    // writes outside the two-register window are dropped
    wrPend_d  = wrStart & (haddr[31:4] == 28'h000_0000);
    wrOff_d   = wrStart ? haddr[3:0] : wrOff_q;
    rdata_d   = 32'h0000_0000;
    ctrl_d    = ctrl_q;
    ti_d      = ti_q;
    // reads answer in the data phase; unmapped offsets read zero
    if (rdStart && haddr[31:4] == 28'h000_0000) begin
      if (haddr[3:0] == `SGF_OFF_CTRL) begin
        rdata_d[2:0] = ctrl_q;
      end else if (haddr[3:0] == `SGF_OFF_STAT) begin
        rdata_d[`SGF_STAT_TI]   = ti_q;
        rdata_d[`SGF_STAT_BUSY] = (state_q != SGF_IDLE);
        rdata_d[`SGF_STAT_HASH] = hashMode_q;
        rdata_d[`SGF_STAT_INV]  = inverse_q;
        rdata_d[`SGF_STAT_SERR] = serr_q;
      end
    end
    if (wrPend_q && wrOff_q == `SGF_OFF_CTRL) begin
      ctrl_d = hwdata[2:0];
    end
    // write one clears, a same-cycle completion still sets
    if (wrPend_q && wrOff_q == `SGF_OFF_STAT && hwdata[`SGF_STAT_TI]) begin
      ti_d = 1'b0;
    end
    if (tiSet) begin
      ti_d = 1'b1; // [RL9]
    end
    // no verdict while disconnected for setup loading [RL6]
    fValid_d  = rxAddrValid && (state_q != SGF_LOAD);
    fAccept_d = rxAddrValid && (state_q != SGF_LOAD) && accept;
  end

  // registers; reset clears the whole table [RL4]
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wrPend_q   <= 1'b0;
      wrOff_q    <= 4'h0;
      rdata_q    <= 32'h0000_0000;
      ctrl_q     <= 3'h0;
      ti_q       <= 1'b0;
      serr_q     <= 1'b0;
      state_q    <= SGF_IDLE;
      desc_q     <= '0;
      wcnt_q     <= 6'h00;
      hashMode_q <= 1'b0;
      inverse_q  <= 1'b0;
      taken_q    <= 1'b0;
      wbValid_q  <= 1'b0;
      wbWord_q   <= 32'h0000_0000;
      fValid_q   <= 1'b0;
      fAccept_q  <= 1'b0;
      for (int k = 0; k < 32; k++) begin
        tbl_q[k] <= 32'h0000_0000;
      end
    end else begin
      wrPend_q   <= wrPend_d;
      wrOff_q    <= wrOff_d;
      rdata_q    <= rdata_d;
      ctrl_q     <= ctrl_d;
      ti_q       <= ti_d;
      serr_q     <= serr_d;
      state_q    <= state_d;
      desc_q     <= desc_d;
      wcnt_q     <= wcnt_d;
      hashMode_q <= hashMode_d;
      inverse_q  <= inverse_d;
      taken_q    <= taken_d;
      wbValid_q  <= wbValid_d;
      wbWord_q   <= wbWord_d;
      fValid_q   <= fValid_d;
      fAccept_q  <= fAccept_d;
      for (int k = 0; k < 32; k++) begin
        tbl_q[k] <= tbl_d[k];
      end
    end
  end

  // small output flops whose values follow the next state and descriptor
  logic        rdy_q;       // buffer ready, high in load
  logic        disc_q;      // receiver disconnected
  logic [28:0] ptr_q;       // setup buffer pointer
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdy_q  <= 1'b0;
      disc_q <= 1'b0;
      ptr_q  <= 29'h0000_0000;
    end else begin
      rdy_q  <= (state_d == SGF_LOAD);
      disc_q <= (state_d == SGF_LOAD); // [RL6]
      ptr_q  <= desc_d.setup_desc_word3[`SGF_PA_HI:`SGF_PA_LO];
    end
  end

  assign hrdata                  = rdata_q;
  assign hreadyout               = 1'b1;
  assign hresp                   = 1'b0;
  assign descTaken               = taken_q;
  assign descWbValid             = wbValid_q;
  assign descWbWord0             = wbWord_q;
  assign bufPhysPointer          = ptr_q;
  assign bufReady                = rdy_q;
  assign rxDisconnect            = disc_q;
  assign filterValid             = fValid_q;
  assign filterAccept            = fAccept_q;
  assign transmit_interrupt_flag = ti_q;
endmodule // sgf_filter_top

// ### sgf_filter_top_bench.sv
// self-checking bench of the setup-frame address filter
`timescale 1ns/1ps
module sgf_filter_top_bench
  import sgf_pkg::*;
;
  // clock, reset and register bus
  logic        sys_clk, sys_rst, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd, wb;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  // descriptor and buffer paths
  sgf_desc_t   desc, descIn;
  logic        offer, slow, descValid, descTaken, descWbValid, tiFlag;
  logic        txQueueEmpty, bufValid, bufReady;
  logic [31:0] descWbWord0, bufData;
  logic [28:0] bufPhysPointer;
  // receive side
  logic        rxBusy, rxAddrValid, rxDisconnect, filterValid, filterAccept;
  logic [47:0] rxAddr;
  int          failures, nChecks, cycles = 0;
  localparam logic [47:0] BASE = 48'h7634_1265_09A0; // exact entry 0
  localparam logic [47:0] MCA = 48'h0027_0025_0025;  // hashed multicast
  localparam logic [47:0] MCB = 48'h8725_3F62_C5A3;  // unhashed multicast
  localparam logic [47:0] STN = 48'h0876_3534_12A8;  // station address
  sgf_filter_top sgf_filter_top_i (
    .sys_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .descValid, .descIn,
    .txQueueEmpty, .descTaken, .descWbValid, .descWbWord0, .bufPhysPointer,
    .bufValid, .bufData, .bufReady, .rxBusy, .rxAddrValid, .rxAddr,
    .rxDisconnect, .filterValid, .filterAccept,
    .transmit_interrupt_flag(tiFlag));
  sgf_host_model sgf_host_model_i (.sys_clk, .offer, .slow, .desc, .descIn,
    .descValid, .descTaken, .bufData, .bufValid, .bufReady);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // hang guard: the tests need a few hundred cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // single word transfer; waits on hready in both phases
  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    rd = hrdata;
    chk(32'(hresp), 32'h0000_0000);
  endtask
  // one destination in, verdict looked at in its single cycle
  task automatic rx(input logic [47:0] a, input logic acc);
    @(posedge sys_clk);
    rxAddrValid <= 1'b1;
    rxAddr <= a;
    @(posedge sys_clk);
    rxAddrValid <= 1'b0;
    @(posedge sys_clk);
    chk(32'({filterValid, filterAccept}), {31'h1, acc});
  endtask
  // queue a setup descriptor: type two, owned, buffer at 0x1000
  task automatic setup(input logic inv, hsh, ic, input logic [14:0] bs);
    desc <= {32'h0000_1000, 1'b0, bs, 16'h0000, 4'h2, 1'b0, inv, hsh, ic,
             24'h00_0000, 32'h8000_0000};
    offer <= 1'b1;
    @(posedge sys_clk);
    offer <= 1'b0;
  endtask
  task automatic finish();
    @(posedge sys_clk iff descWbValid === 1'b1);
    wb = descWbWord0;
    @(posedge sys_clk);
  endtask
  function automatic logic [8:0] hidx(input logic [47:0] a);
    logic [31:0] c;
    c = 32'hFFFF_FFFF;
    for (int i = 0; i < 48; i++) c = {c[30:0], 1'b0} ^ ((c[31] ^ a[i]) ?
      32'h04C1_1DB7 : 32'h0000_0000);
    for (int i = 0; i < 9; i++) hidx[8-i] = c[23+i];
  endfunction
  task automatic t_reset();
    rx(48'h0, 1'b1);
    rx(STN, 1'b0);
    rx(MCA, 1'b0);
    ahb(1'b0, 32'h0000_0040, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b1, 32'h0000_0040, 32'h0000_0007);
    ahb(1'b0, 32'h0000_0000, 32'h0);
    chk(rd, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_perfect();
    for (int i = 0; i < 16; i++) begin
      sgf_host_model_i.mem[2*i] = BASE[31:0] + 32'(i);
      sgf_host_model_i.mem[2*i+1] = {16'hABCD, BASE[47:32]};
    end
    rxBusy <= 1'b1;
    setup(1'b0, 1'b0, 1'b1, 15'h0080);
    ahb(1'b1, 32'h0, 32'h1);
    repeat (8) @(posedge sys_clk);
    chk(32'(bufReady), 32'h0);
    rxBusy <= 1'b0;
    txQueueEmpty <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk(32'(bufReady), 32'h0);
    txQueueEmpty <= 1'b1;
    slow <= 1'b1;
    @(posedge sys_clk iff bufReady === 1'b1);
    chk(32'(rxDisconnect), 32'h1);
    chk(32'(bufPhysPointer), 32'h0000_0800);
    finish();
    slow <= 1'b0;
    chk(wb, 32'h0);
    chk(32'(tiFlag), 32'h1);
    rx(BASE, 1'b1);
    rx(BASE + 48'hF, 1'b1);
    rx(BASE + 48'h10, 1'b0);
    ahb(1'b1, 32'h4, 32'h1);
    ahb(1'b0, 32'h4, 32'h0);
    chk(rd, 32'h0);
    $display("perfect test done");
  endtask
  task automatic t_inverse();
    setup(1'b1, 1'b0, 1'b0, 15'h0080);
    finish();
    chk(32'(tiFlag), 32'h0);
    rx(BASE + 48'h3, 1'b0);
    rx(BASE + 48'h10, 1'b1);
    ahb(1'b1, 32'h0, 32'h5);
    rx(BASE + 48'h2, 1'b1);
    rx(BASE + 48'h10, 1'b0);
    ahb(1'b1, 32'h0, 32'h1);
    $display("inverse test done");
  endtask
  task automatic t_hash();
    logic [8:0] h;
    h = hidx(MCA);
    for (int i = 0; i < 32; i++) sgf_host_model_i.mem[i] = 32'h0;
    sgf_host_model_i.mem[h[8:5]][h[4:0]] = 1'b1;
    sgf_host_model_i.mem[16] = STN[31:0];
    sgf_host_model_i.mem[17] = {16'h0000, STN[47:32]};
    setup(1'b0, 1'b1, 1'b1, 15'h0080);
    finish();
    rx(MCA, 1'b1);
    if (hidx(MCB) != h) rx(MCB, 1'b0);
    rx(STN, 1'b1);
    rx(STN ^ 48'h100, 1'b0);
    ahb(1'b0, 32'h4, 32'h0);
    chk(rd, 32'h5);
    ahb(1'b1, 32'h4, 32'h1);
    $display("hash test done");
  endtask
  task automatic t_size();
    setup(1'b0, 1'b0, 1'b0, 15'h0040);
    finish();
    chk(wb, 32'h0000_A000);
    chk(32'(tiFlag), 32'h0);
    rx(STN, 1'b1);
    ahb(1'b0, 32'h4, 32'h0);
    chk(rd, 32'h14);
    // a reset in mid-run must wipe the loaded table again
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rx(STN, 1'b0);
    rx(48'h0, 1'b1);
    $display("size test done");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", nChecks, failures);
    if (failures == 0 && nChecks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    {sys_rst, hsel, hwrite, offer, slow, rxBusy, rxAddrValid} = 7'h40;
    {haddr, hwdata, htrans, desc, rxAddr} = '0;
    hsize = 3'h2;
    txQueueEmpty = 1'b1;
    failures = 0;
    nChecks = 0;
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_perfect();
    t_inverse();
    t_hash();
    t_size();
    end_of_test();
  end
endmodule // sgf_filter_top_bench

// ### sgf_hash_crc.sv
// hash index from the ethernet crc of a destination address
`timescale 1ns/1ps
module sgf_hash_crc
  import sgf_pkg::*;
(
  // address, first byte in bits 7:0
  input  wire logic [47:0] dstAddr,
  // nine-bit table index
  output logic      [8:0]  hashIdx
);
`include "sgf_cfg.svh"
  // residue bit k of the shift model sits at crc[k-1]
  always_comb begin
    logic [31:0] crc;
    logic        mean;
    crc = `SGF_CRC_INIT; // [RL19]
    mean = 1'b0;
    // low 32 bits then high 16, lsb first, one bit per step
    for (int j = 0; j < 48; j++) begin // [RL19]
      mean = crc[31] ^ dstAddr[j];
      crc = {crc[30:0], 1'b0} ^ (mean ? `SGF_CRC_POLY : 32'h0000_0000);
    end
    // top nine residue bits, highest index first [RL16]
    for (int k = 0; k < 9; k++) begin
      hashIdx[8-k] = crc[23+k];
    end
  end
endmodule // sgf_hash_crc

// ### sgf_host_model.sv
// host-side model: offers one setup descriptor and feeds its buffer
`timescale 1ns/1ps
module sgf_host_model
  import sgf_pkg::*;
(
  // clock
  input  wire logic      sys_clk,
  // bench controls
  input  wire logic      offer,
  input  wire logic      slow,
  input  wire sgf_desc_t desc,
  // descriptor handshake
  output sgf_desc_t      descIn,
  output logic           descValid,
  input  wire logic      descTaken,
  // buffer handshake
  output logic [31:0]    bufData,
  output logic           bufValid,
  input  wire logic      bufReady
);
  logic [31:0] mem [32];    // buffer image, always 128 bytes
  logic [5:0]  idx = '0;    // next longword to hand over
  logic [5:0]  nxt;         // index after this edge's transfer
  logic        tick = 1'b0; // pacing for slow mode
  initial begin
    descValid = 1'b0;
    descIn = '0;
    bufValid = 1'b0;
    bufData = '0;
  end
  // offer is owned by the device and held until taken
  always @(posedge sys_clk) begin
    tick <= ~tick;
    if (offer) begin
      descValid <= 1'b1;
      descIn <= desc;
      bufValid <= 1'b0;
      idx <= '0;
    end else begin
      if (descTaken) descValid <= 1'b0;
      nxt = idx + 6'(bufValid && bufReady);
      idx <= nxt;
      // a word stands until taken; all sixteen entries always sent
      if (!(bufValid && !bufReady)) begin
        bufValid <= nxt < 6'h20 && (!slow || tick);
        // an idle data bus shows the inverse of its previous value
        bufData <= (nxt < 6'h20 && (!slow || tick)) ?
                   mem[nxt[4:0]] : ~bufData;
      end
    end
  end
endmodule // sgf_host_model

// ### sgf_match.sv
// compares a destination against the sixteen exact entries
`timescale 1ns/1ps
module sgf_match
  import sgf_pkg::*;
#(
  parameter int ENTRIES = 16
)(
  // destination and stored entries
  input  wire logic [47:0]         dstAddr,
  input  wire logic [ENTRIES*48-1:0] entries,
  // any entry equal
  output logic                     hit
);
  logic [ENTRIES-1:0] eq; // per-entry equality

  // one comparator per entry [RL1]
  for (genvar i = 0; i < ENTRIES; i++) begin : g_cmp
    assign eq[i] = (entries[i*48 +: 48] == dstAddr);
  end
  assign hit = |eq;
endmodule // sgf_match

// ### sgf_pkg.sv
// types shared by the setup-frame address filter
package sgf_pkg;
  // setup sequencer, gray along idle-wait-load-done
  typedef enum logic [1:0] {
    SGF_IDLE = 2'h0,
    SGF_WAIT = 2'h1,
    SGF_LOAD = 2'h3,
    SGF_DONE = 2'h2
  } sgf_state_t;
  // the four setup descriptor words
  typedef struct packed {
    logic [31:0] setup_desc_word3;
    logic [31:0] setup_desc_word2;
    logic [31:0] setup_desc_word1;
    logic [31:0] setup_desc_word0;
  } sgf_desc_t;
endpackage
